// ===== hdl/mmt_pkg.sv
// Package: register map, field positions and constants for the motor mode timer unit
// Summary of operation
// - Timer stops at all-ones on overflow and sets the overflow flag
// - Control B bit 5 reports timer overflow
// - Control A bit 4 lets each timeout compare event clear the timer
// - Control A bit 3 lets overload assertion clear the timer
// - Writing 1 to control A bit 2 clears the timer
// - Control A bit 1 lets each position detection event clear the timer
// - Control A bit 0 starts the timer counting on the selected clock
// - Disabling the timer cancels all armed compare channels
// - Control A bits 7 to 5 select the timer clock
// - Channels act only while running; fire once, disarm, or disarm on clear
// - Commutation channel fires when count is greater than or equal to compare
// - A late commutation compare below the count still fires
// - Detect-start and timeout channels fire only on exact equality
// - Any compare write rearms that channel, even with an unchanged value
// - Control B bit 1 captures the count on each position detection
// - Control B bit 3 captures the count on overload assertion
// - Writing 1 to control B bit 2 captures the live count
// - Control B bit 7 drives interrupt requests out for observation
// - Capture and compare registers are 16 bits and reset to zero
package mmt_pkg;
	// Byte offsets on APB
	localparam logic [7:0]  OFS_CTRL_A     = 8'h00;
	localparam logic [7:0]  OFS_CTRL_B     = 8'h04;
	localparam logic [7:0]  OFS_CAPTURE    = 8'h08;
	localparam logic [7:0]  OFS_COMMUTATION_COMPARE       = 8'h0c;
	localparam logic [7:0]  OFS_DETECT_START_COMPARE       = 8'h10;
	localparam logic [7:0]  OFS_TIMEOUT_COMPARE       = 8'h14;
	// Control A fields
	localparam int          A_EN           = 0;
	localparam int          A_DET_CLR      = 1;
	localparam int          A_SW_CLR       = 2;
	localparam int          A_OVL_CLR      = 3;
	localparam int          A_TO_CLR       = 4;
	localparam int          A_CKSEL_LO     = 5;
	// Control B fields
	localparam int          B_DET_CAP      = 1;
	localparam int          B_SW_CAP       = 2;
	localparam int          B_OVL_CAP      = 3;
	localparam int          B_OVF          = 5;
	localparam int          B_DBG          = 7;
	// Reset values and limits
	localparam logic [15:0] CNT_MAX        = 16'hffff;
	localparam logic [15:0] REG16_RST      = 16'h0000;
	localparam logic [7:0]  REG8_RST       = 8'h00;
	localparam logic [7:0]  CTRL_B_WMASK   = 8'h8a;
	localparam logic [2:0]  CKSEL_RST      = 3'h0;
	localparam logic [3:0]  DIV_ZERO       = 4'h0;
	localparam logic [7:0]  CNT_ONE        = 8'h01;
endpackage
`default_nettype wire

// ===== hdl/mmt_timer_unit.sv
// Motor mode timer unit: 16-bit mode timer, capture, three compare channels, APB slave
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mmt_timer_unit
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        position_detect_irq,
	input  wire logic        overload_signal,
	output logic             commutation_irq,
	output logic             detect_start_irq,
	output logic             timeout_irq,
	output logic      [2:0]  debug_port
);

	// Address decode shared by read and write paths
	function automatic logic [2:0] dec(input logic [7:0] a);
		unique case (a)
			mmt_pkg::OFS_CTRL_A:  return 3'h0;
			mmt_pkg::OFS_CTRL_B:  return 3'h1;
			mmt_pkg::OFS_CAPTURE: return 3'h2;
			mmt_pkg::OFS_COMMUTATION_COMPARE:    return 3'h3;
			mmt_pkg::OFS_DETECT_START_COMPARE:    return 3'h4;
			mmt_pkg::OFS_TIMEOUT_COMPARE:    return 3'h5;
			default:              return 3'h7;
		endcase
	endfunction

	logic [7:0]  ctrl_a_r;
	logic [7:0]  ctrl_b_r;
	logic        ovf_r;
	logic [15:0] count_r;
	logic [15:0] cap_r;
	logic [15:0] cmp_r [3];
	logic [2:0]  armed_r;
	logic [7:0]  div_r;
	logic [2:0]  pd_sync_r;
	logic [2:0]  ov_sync_r;
	logic        pd_lvl_r;
	logic        ov_lvl_r;
	logic        acc;
	logic        wr;
	logic [2:0]  sel;
	logic        tick;
	logic        pd_ev;
	logic        ov_ev;
	logic        sw_clr;
	logic        sw_cap;
	logic [2:0]  hit;
	logic        clr;
	logic        cap;
	logic        running;
	logic        stop_wr;

	assign acc     = psel & penable;
	assign wr      = acc & pwrite;
	assign sel     = dec(paddr);
	assign running = ctrl_a_r[mmt_pkg::A_EN];
	// Only stopping a running timer cancels; compares loaded before enable must survive
	assign stop_wr = running & wr & (sel == 3'h0) & ~pwdata[mmt_pkg::A_EN];
	// Prescaler taps: all low bits ones marks the divided tick
	assign tick    = running & ((ctrl_a_r[7:5] == 3'h0) |
		(&(div_r | ~((mmt_pkg::CNT_ONE << ctrl_a_r[7:5]) - mmt_pkg::CNT_ONE))));
	// Requests from software live only in the write cycle, never stored
	assign sw_clr  = wr & (sel == 3'h0) & pwdata[mmt_pkg::A_SW_CLR];
	assign sw_cap  = wr & (sel == 3'h1) & pwdata[mmt_pkg::B_SW_CAP];

	// Three-stage synchronisers; a level counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			pd_sync_r <= 3'h0;
			ov_sync_r <= 3'h0;
			pd_lvl_r  <= 1'b0;
			ov_lvl_r  <= 1'b0;
		end
		else
		begin
			pd_sync_r <= {pd_sync_r[1:0], position_detect_irq};
			ov_sync_r <= {ov_sync_r[1:0], overload_signal};
			if (pd_sync_r[1] == pd_sync_r[2])
				pd_lvl_r <= pd_sync_r[2];
			if (ov_sync_r[1] == ov_sync_r[2])
				ov_lvl_r <= ov_sync_r[2];
		end

	// Rising edges of the filtered levels are the events
	assign pd_ev = (pd_sync_r[1] == pd_sync_r[2]) & pd_sync_r[2] & ~pd_lvl_r;
	assign ov_ev = (ov_sync_r[1] == ov_sync_r[2]) & ov_sync_r[2] & ~ov_lvl_r;

	// Compare hits; only armed channels on a running timer count
	assign hit[0] = running & armed_r[0] & (count_r >= cmp_r[0]);
	assign hit[1] = running & armed_r[1] & (count_r == cmp_r[1]);
	assign hit[2] = running & armed_r[2] & (count_r == cmp_r[2]);

	// Clear sources collected
	assign clr = sw_clr
		| (ctrl_a_r[mmt_pkg::A_TO_CLR] & hit[2])
		| (ctrl_a_r[mmt_pkg::A_OVL_CLR] & ov_ev)
		| (ctrl_a_r[mmt_pkg::A_DET_CLR] & pd_ev);
	// Capture sources collected
	assign cap = sw_cap
		| (ctrl_b_r[mmt_pkg::B_OVL_CAP] & ov_ev)
		| (ctrl_b_r[mmt_pkg::B_DET_CAP] & pd_ev);

	// Free prescaler; held at zero while stopped so each start is aligned
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			div_r <= 8'h00;
		else if (!running)
			div_r <= 8'h00;
		else
			div_r <= div_r + mmt_pkg::CNT_ONE;

	// Mode timer: clear wins, otherwise count and saturate
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			count_r <= mmt_pkg::REG16_RST;
		else if (clr)
			count_r <= mmt_pkg::REG16_RST;
		else if (tick && count_r != mmt_pkg::CNT_MAX)
			count_r <= count_r + 16'h0001;

	// Overflow flag: set at saturation; write 0 to bit 5 clears, set wins
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ovf_r <= 1'b0;
		else if (tick && !clr && count_r == mmt_pkg::CNT_MAX)
			ovf_r <= 1'b1;
		else if (wr && sel == 3'h1 && !pwdata[mmt_pkg::B_OVF])
			ovf_r <= 1'b0;

	// Capture takes the pre-clear count, so a full interval is recorded
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			cap_r <= mmt_pkg::REG16_RST;
		else if (cap)
			cap_r <= count_r;

	// Control registers; soft clear and capture bits are never stored
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			ctrl_a_r <= mmt_pkg::REG8_RST;
			ctrl_b_r <= mmt_pkg::REG8_RST;
		end
		else if (wr)
		begin
			if (sel == 3'h0)
				ctrl_a_r <= pwdata[7:0] & ~(8'h01 << mmt_pkg::A_SW_CLR);
			if (sel == 3'h1)
				ctrl_b_r <= pwdata[7:0] & mmt_pkg::CTRL_B_WMASK;
		end

	// Compare registers and arming per channel
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_ch
			always_ff @(posedge pclk or negedge presetn)
				if (!presetn)
				begin
					cmp_r[g]   <= mmt_pkg::REG16_RST;
					armed_r[g] <= 1'b0;
				end
				else if (wr && sel == 3'(g + 3))
				begin
					cmp_r[g]   <= pwdata[15:0];
					armed_r[g] <= 1'b1;
				end
				else if (stop_wr || hit[g] || clr)
					armed_r[g] <= 1'b0;
		end
	endgenerate

	// Interrupt pulses, one cycle each, straight from flip-flops
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			commutation_irq  <= 1'b0;
			detect_start_irq <= 1'b0;
			timeout_irq      <= 1'b0;
			debug_port       <= 3'h0;
		end
		else
		begin
			commutation_irq  <= hit[0];
			detect_start_irq <= hit[1];
			timeout_irq      <= hit[2];
			debug_port       <= ctrl_b_r[mmt_pkg::B_DBG] ? hit : 3'h0;
		end

	// APB: one wait-free access phase; unmapped addresses answer with an error
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & (sel == 3'h7);
			prdata  <= 32'h0000_0000;
			if (psel && !penable && !pwrite)
				unique case (sel)
					3'h0:    prdata <= {24'h000000, ctrl_a_r};
					3'h1:    prdata <= {24'h000000, ctrl_b_r | ({7'h00, ovf_r} << mmt_pkg::B_OVF)};
					3'h2:    prdata <= {16'h0000, cap_r};
					3'h3:    prdata <= {16'h0000, cmp_r[0]};
					3'h4:    prdata <= {16'h0000, cmp_r[1]};
					3'h5:    prdata <= {16'h0000, cmp_r[2]};
					default: prdata <= 32'h0000_0000;
				endcase
		end

	// Checks on counting, clearing, arming and capture
	// Saturation holds the count at all-ones
	a_sat_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(count_r == mmt_pkg::CNT_MAX && !clr) |=> count_r == mmt_pkg::CNT_MAX)
		else $error("timer left all-ones without clear");

	// Overflow flag follows a tick at all-ones
	a_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && !clr && count_r == mmt_pkg::CNT_MAX) |=> ovf_r)
		else $error("overflow flag not set");

	// Flag only drops through a register write
	a_ovf_keep: assert property (@(posedge pclk) disable iff (!presetn)
		(ovf_r && !wr) |=> ovf_r)
		else $error("overflow flag dropped by itself");

	// Flag appears in bit 5 of the read word
	a_ovf_read: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && sel == 3'h1) |=> prdata[mmt_pkg::B_OVF] == $past(ovf_r))
		else $error("overflow flag not readable");

	// Timeout compare clears when enabled
	a_to_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(hit[2] && ctrl_a_r[mmt_pkg::A_TO_CLR]) |=> count_r == 16'h0000)
		else $error("timeout compare did not clear timer");

	// Overload clears when enabled
	a_ovl_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(ov_ev && ctrl_a_r[mmt_pkg::A_OVL_CLR]) |=> count_r == 16'h0000)
		else $error("overload did not clear timer");

	// Soft clear works at once and is not stored
	a_sw_clear: assert property (@(posedge pclk) disable iff (!presetn)
		sw_clr |=> (count_r == 16'h0000 && !ctrl_a_r[mmt_pkg::A_SW_CLR]))
		else $error("soft clear failed");

	// Detection clears when enabled
	a_det_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(pd_ev && ctrl_a_r[mmt_pkg::A_DET_CLR]) |=> count_r == 16'h0000)
		else $error("detection did not clear timer");

	// A stopped timer holds its value
	a_stop_idle: assert property (@(posedge pclk) disable iff (!presetn)
		(!running && !clr) |=> $stable(count_r))
		else $error("timer moved while disabled");

	// Each tick below all-ones adds one
	a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
		(tick && !clr && count_r != mmt_pkg::CNT_MAX) |=> count_r == $past(count_r) + 16'h0001)
		else $error("count did not step");

	// Stopping a running timer cancels every armed channel
	a_disarm_off: assert property (@(posedge pclk) disable iff (!presetn)
		stop_wr |=> armed_r == 3'h0)
		else $error("channel armed after stop");

	// Undivided clock ticks on every edge
	a_tick_base: assert property (@(posedge pclk) disable iff (!presetn)
		(running && ctrl_a_r[7:5] == 3'h0) |-> tick)
		else $error("undivided tick missing");

	// Commutation disarms after firing unless rewritten
	a_fire_once: assert property (@(posedge pclk) disable iff (!presetn)
		(hit[0] && !(wr && sel == 3'h3)) |=> !armed_r[0])
		else $error("commutation stayed armed");

	// Detect start disarms after firing unless rewritten
	a_ds_disarm: assert property (@(posedge pclk) disable iff (!presetn)
		(hit[1] && !(wr && sel == 3'h4)) |=> !armed_r[1])
		else $error("detect start stayed armed");

	// Timeout disarms after firing unless rewritten
	a_to_disarm: assert property (@(posedge pclk) disable iff (!presetn)
		(hit[2] && !(wr && sel == 3'h5)) |=> !armed_r[2])
		else $error("timeout stayed armed");

	// A clear disarms all channels not rewritten in that cycle
	a_clr_disarm: assert property (@(posedge pclk) disable iff (!presetn)
		(clr && !(wr && sel > 3'h2)) |=> armed_r == 3'h0)
		else $error("clear left a channel armed");

	// Magnitude compare fires at or past the value
	a_mag_cmp: assert property (@(posedge pclk) disable iff (!presetn)
		(running && armed_r[0] && count_r >= cmp_r[0]) |=> commutation_irq)
		else $error("magnitude compare missed");

	// Magnitude compare stays quiet below the value
	a_mag_miss: assert property (@(posedge pclk) disable iff (!presetn)
		(running && armed_r[0] && count_r < cmp_r[0]) |=> !commutation_irq)
		else $error("magnitude compare fired early");

	// Detect start only on equality
	a_eq_cmp: assert property (@(posedge pclk) disable iff (!presetn)
		detect_start_irq |-> $past(count_r) == $past(cmp_r[1]))
		else $error("detect start fired off equality");

	// Timeout only on equality
	a_to_eq: assert property (@(posedge pclk) disable iff (!presetn)
		timeout_irq |-> $past(count_r) == $past(cmp_r[2]))
		else $error("timeout fired off equality");

	// Armed detect start fires on equality
	a_ds_fire: assert property (@(posedge pclk) disable iff (!presetn)
		(running && armed_r[1] && count_r == cmp_r[1]) |=> detect_start_irq)
		else $error("detect start missed equality");

	// Commutation compare writes rearm their channel
	a_rearm: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && sel == 3'h3) |=> armed_r[0])
		else $error("compare write did not rearm");

	// Detect start write rearms
	a_rearm_ds: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && sel == 3'h4) |=> armed_r[1])
		else $error("detect start write did not rearm");

	// Timeout write rearms
	a_rearm_to: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && sel == 3'h5) |=> armed_r[2])
		else $error("timeout write did not rearm");

	// Detection captures when enabled
	a_det_cap: assert property (@(posedge pclk) disable iff (!presetn)
		(pd_ev && ctrl_b_r[mmt_pkg::B_DET_CAP]) |=> cap_r == $past(count_r))
		else $error("detection capture missed");

	// Overload captures when enabled
	a_ovl_cap: assert property (@(posedge pclk) disable iff (!presetn)
		(ov_ev && ctrl_b_r[mmt_pkg::B_OVL_CAP]) |=> cap_r == $past(count_r))
		else $error("overload capture missed");

	// Soft capture takes the live count
	a_swcap_val: assert property (@(posedge pclk) disable iff (!presetn)
		sw_cap |=> cap_r == $past(count_r))
		else $error("soft capture missed");

	// Any capture takes the count from before a simultaneous clear
	a_cap_pre: assert property (@(posedge pclk) disable iff (!presetn)
		cap |=> cap_r == $past(count_r))
		else $error("capture value wrong");

	// Capture register holds between triggers
	a_cap_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!cap |=> $stable(cap_r))
		else $error("capture register moved");

	// Soft capture bit reads back as zero
	a_req_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && sel == 3'h1) |=> !prdata[mmt_pkg::B_SW_CAP])
		else $error("soft capture bit read back");

	// Debug pins silent while disabled
	a_dbg_out: assert property (@(posedge pclk) disable iff (!presetn)
		(!ctrl_b_r[mmt_pkg::B_DBG]) |=> debug_port == 3'h0)
		else $error("debug output without enable");

	// Debug pins mirror the compare hits
	a_dbg_mirror: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl_b_r[mmt_pkg::B_DBG] |=> debug_port == $past(hit))
		else $error("debug output does not mirror hits");

endmodule // mmt_timer_unit
`default_nettype wire

// ===== tb/mmt_far_side.sv
// Far-side model: position detection and overload protection lines
`timescale 1ns/1ps
`default_nettype none
module mmt_far_side
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic [1:0] fire,
	output logic            position_detect_irq,
	output logic            overload_signal
);
	logic [3:0] hold_r;
	logic [1:0] src_r;
	// Level held 8 clocks so the unit's 3-flop sync cannot miss it
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			{hold_r, src_r} <= 6'h00;
		else if (fire != 2'h0)
			{hold_r, src_r} <= {4'h8, fire};
		else if (hold_r != 4'h0)
			hold_r <= hold_r - 4'h1;
	// Lines rest low between events
	assign position_detect_irq = src_r[0] && hold_r != 4'h0;
	assign overload_signal     = src_r[1] && hold_r != 4'h0;
endmodule // mmt_far_side
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the motor mode timer unit
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, pdi, ovl;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0]  irq, dbg;
	logic [1:0]  fire;
	logic [15:0] v0, v1;
	logic [33:0] e;
	logic [33:0] exp_q[$];
	int          failures, checks_done, cyc, c0, cw, d, we, n[6], b[6];
	mmt_timer_unit mmt_timer_unit_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .position_detect_irq(pdi), .overload_signal(ovl), .commutation_irq(irq[0]),
		.detect_start_irq(irq[1]), .timeout_irq(irq[2]), .debug_port(dbg));
	mmt_far_side mmt_far_side_i (.pclk(pclk), .presetn(presetn), .fire(fire),
		.position_detect_irq(pdi), .overload_signal(ovl));
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// Clock and pulse tally; debug bits beside the irqs they mirror
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		for (int i = 0; i < 3; i++)
		begin
			n[i] <= n[i] + int'(irq[i]);
			n[i + 3] <= n[i + 3] + int'(dbg[i]);
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Each read answer is matched to the oldest noted expectation
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			e = exp_q.pop_front();
			rd = prdata;
			if (e[33])
			begin
				chk("prdata", prdata, e[31:0]);
				chk("pslverr", 32'(pslverr), 32'(e[32]));
			end
		end
	// Request held until pready is seen; an edge passes before the next one
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dt);
		int t;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dt;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do
		begin
			@(posedge pclk);
			t++;
		end
		while (pready !== 1'b1 && t < 16);
		if (t == 16)
		begin
			failures++;
			final_report;
		end
		we = cyc;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dt);
		xfer(1'b1, a, dt);
	endtask
	task automatic rdq(input logic [7:0] a, input logic [31:0] dt, input logic c);
		exp_q.push_back({c, a == 8'h18, dt});
		xfer(1'b0, a, dt);
	endtask
	// Software capture, the only view of the live count
	task automatic cap(output logic [15:0] v);
		wr(8'h04, 32'h4);
		cw = we;
		rdq(8'h08, 32'h0, 1'b0);
		v = rd[15:0];
	endtask
	task automatic final_report;
		$display("Checks %0d mismatches %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Watchdog: the whole run needs about 7 ms
	initial
	begin
		#9ms;
		failures++;
		final_report;
	end
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, fire} = '0;
		presetn = 1'b0;
		failures = 0;
		checks_done = 0;
		cyc = 0;
		n = '{default: 0};
		void'($urandom(32'h9bdf));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values, then one unmapped word
		for (int a = 0; a < 7; a++)
			rdq(8'(a * 4), 32'h0, 1'b1);
		for (int i = 0; i < 3; i++)
		begin
			d = $urandom;
			wr(8'(12 + i * 4), 32'(d));
			rdq(8'(12 + i * 4), {16'h0, 16'(d)}, 1'b1);
		end
		// Request bits read 0; capture ignores writes
		wr(8'h00, 32'h4);
		rdq(8'h00, 32'h0, 1'b1);
		wr(8'h04, 32'h8e);
		rdq(8'h04, 32'h8a, 1'b1);
		wr(8'h08, 32'hffff);
		rdq(8'h08, 32'h0, 1'b1);
		// Select changed only while stopped; rate is pclk over 2**sel
		for (int s = 0; s < 4; s++)
		begin
			wr(8'h00, 32'h0);
			wr(8'h00, 32'(s) << 5);
			wr(8'h00, (32'(s) << 5) | 32'h1);
			cap(v0);
			c0 = cw;
			repeat (40) @(posedge pclk);
			cap(v1);
			d = cw - c0;
			chk("rate", 32'(v1 - v0 >= 16'(d >> s) && v1 - v0 <= 16'((d + (1 << s) - 1) >> s)), 32'h1);
		end
		// Left alone the count parks at all ones and flags it
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h5);
		repeat (65600) @(posedge pclk);
		wr(8'h04, 32'h4);
		rdq(8'h08, 32'hffff, 1'b1);
		rdq(8'h04, 32'h20, 1'b1);
		// Channels with timeout clearing the count and the debug mirror on
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h4);
		wr(8'h04, 32'h80);
		b = n;
		wr(8'h0c, 32'h40);
		wr(8'h10, 32'h50);
		wr(8'h14, 32'h100);
		wr(8'h00, 32'h11);
		repeat (400) @(posedge pclk);
		wr(8'h14, 32'h100);
		repeat (300) @(posedge pclk);
		wr(8'h0c, 32'h1);
		repeat (5) @(posedge pclk);
		wr(8'h10, 32'h400);
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h1);
		repeat (1100) @(posedge pclk);
		chk("commutation count", 32'(n[0] - b[0]), 32'h2);
		chk("detect start count", 32'(n[1] - b[1]), 32'h1);
		chk("timeout count", 32'(n[2] - b[2]), 32'h2);
		for (int i = 0; i < 3; i++)
			chk("debug count", 32'(n[i + 3] - b[i + 3]), 32'(n[i] - b[i]));
		// Each event captures the count from before the clear it causes
		for (int k = 0; k < 2; k++)
		begin
			wr(8'h00, 32'h5 | (32'h2 << (2 * k)));
			c0 = we;
			wr(8'h04, 32'h2 << (2 * k));
			repeat (100) @(posedge pclk);
			fire <= 2'(1 << k);
			d = cyc - c0;
			@(posedge pclk);
			fire <= 2'h0;
			repeat (20) @(posedge pclk);
			rdq(8'h08, 32'h0, 1'b0);
			chk("event capture", 32'(rd >= d && rd <= d + 10), 32'h1);
			cap(v1);
			chk("event clear", 32'(v1 < 16'h0028), 32'h1);
		end
		final_report;
	end
endmodule // tb
`default_nettype wire
